/* File: verilog/mbs_handler.v */
/*
  modbus slave query handler for functions 02, 03, 04, 05.
  assumes: query bytes arrive framed with a check result from the link layer;
  the answer bytes leave through an 8-byte fifo; check bytes are appended outside.
  data tables live in host logic and are read by index.
*/
`include "mbs_regs.vh"
module mbs_handler #(
  parameter INPUTS  = 256,
  parameter REGS    = 64,
  parameter COILS   = 256,
  parameter IAW     = 8,
  parameter RAW     = 6,
  parameter CAW     = 8
) (
  input  wire              mclk,
  input  wire              rst_n,
  input  wire [7:0]        slave_id,
  input  wire [7:0]        rx_data,
  input  wire              rx_valid,
  input  wire              rx_end,
  input  wire              rx_check_ok,
  input  wire              scan_end,
  input  wire [INPUTS-1:0] in_bits,
  input  wire [16*REGS-1:0] hold_regs,
  input  wire [16*REGS-1:0] in_regs,
  output reg  [COILS-1:0]  coil_state,
  output reg               coil_wr,
  output reg  [CAW-1:0]    coil_addr,
  output reg               coil_val,
  output reg  [7:0]        tx_data,
  output reg               tx_valid,
  output reg               tx_last,
  input  wire              tx_ready,
  output reg               busy
);
  localparam S_RX   = 3'h0;
  localparam S_EXEC = 3'h1;
  localparam S_HEAD = 3'h2;
  localparam S_DATA = 3'h3;
  localparam S_ECHO = 3'h4;

  reg [7:0]          q [0:5];
  reg [2:0]          rx_cnt;
  reg [2:0]          state;
  reg [INPUTS-1:0]   snap_bits;
  reg [16*REGS-1:0]  snap_hold;
  reg [16*REGS-1:0]  snap_inreg;
  reg [15:0]         idx;
  reg [7:0]          remain;
  reg [7:0]          byte_cnt;
  reg [1:0]          head;
  reg                hi_half;
  reg [7:0]          f_data;
  reg                f_valid;
  reg                f_last;
  reg [2:0]          echo_i;
  wire [7:0]         o_data;
  wire               o_valid;
  wire               f_ready;

  wire [15:0] q_start = {q[2], q[3]};
  wire [15:0] q_qty   = {q[4], q[5]};
  wire        bcast   = (q[0] == `MBS_BCAST_ADDR);
  wire        mine    = (q[0] == slave_id);

  function ok_on_bcast;
    input [7:0] fn;
    ok_on_bcast = (fn == `MBS_FN_FORCE_COIL) || (fn == `MBS_FN_PRESET_REG) ||
                  (fn == `MBS_FN_FORCE_MULT) || (fn == `MBS_FN_PRESET_MUL);
  endfunction

  // register byte from a snapshot, high byte first
  function [7:0] reg_byte;
    input [16*REGS-1:0] tbl;
    input [15:0]        i;
    input               hi;
    reg   [15:0]        w;
    begin
      w = tbl[16*i[RAW-1:0] +: 16];
      reg_byte = hi ? w[15:8] : w[7:0];
    end
  endfunction

  // one packed byte of inputs starting at index, zero above the count
  function [7:0] bit_byte;
    input [INPUTS-1:0] tbl;
    input [15:0]       i;
    input [7:0]        left;
    integer            k;
    begin
      bit_byte = 8'h00;
      for (k = 0; k < 8; k = k + 1) begin
        if (k < left)
          bit_byte[k] = tbl[(i[IAW-1:0] + k) % INPUTS];
      end
    end
  endfunction

  wire is_bits = (q[1] == `MBS_FN_RD_INPUTS);
  wire is_regs = (q[1] == `MBS_FN_RD_HOLD) || (q[1] == `MBS_FN_RD_INREG);
  wire bits_ok = (q_qty != 16'h0000) && (q_qty <= `MBS_MAX_BITS) &&
                 ({16'h0000, q_start} + q_qty <= INPUTS);
  wire regs_ok = (q_qty != 16'h0000) && (q_qty <= `MBS_MAX_REGS) &&
                 ({16'h0000, q_start} + q_qty <= REGS);
  wire coil_ok = (q_start < COILS);

  mbs_fifo #(.WIDTH(8), .DEPTH(8), .AW(3)) u_fifo (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .in_data   (f_data),
    .in_valid  (f_valid),
    .in_ready  (f_ready),
    .out_data  (o_data),
    .out_valid (o_valid),
    .out_ready (tx_ready || !tx_valid)
  );
  // last-byte marker tracked beside the fifo
  reg [3:0] last_pend;
  wire      f_push = f_valid && f_ready;
  wire      o_pop  = o_valid && (tx_ready || !tx_valid);

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_data   <= 8'h00;
      tx_valid  <= 1'b0;
      tx_last   <= 1'b0;
      last_pend <= 4'h0;
    end else begin
      if (o_pop) begin
        tx_data  <= o_data;
        tx_valid <= 1'b1;
        tx_last  <= (last_pend == 4'h1);
      end else if (tx_ready) begin
        tx_valid <= 1'b0;
        tx_last  <= 1'b0;
      end
      if (f_push && f_last)
        last_pend <= (o_pop && last_pend != 4'h0) ? last_pend : 4'h1 + last_pend;
      else if (o_pop && last_pend != 4'h0 && f_push)
        last_pend <= last_pend;
      else if (o_pop && last_pend != 4'h0)
        last_pend <= last_pend - 4'h1;
      else if (f_push)
        last_pend <= last_pend + 4'h1;
    end
  end

  // snapshots refresh only at end of scan
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      snap_bits  <= {INPUTS{1'b0}};
      snap_hold  <= {16*REGS{1'b0}};
      snap_inreg <= {16*REGS{1'b0}};
    end else if (scan_end && state == S_RX) begin
      snap_bits  <= in_bits;
      snap_hold  <= hold_regs;
      snap_inreg <= in_regs;
    end
  end

  // coils kept apart from rst_n so forced states persist
  always @(posedge mclk) begin
    if (coil_wr)
      coil_state[coil_addr] <= coil_val;
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= S_RX;
      rx_cnt   <= 3'h0;
      idx      <= 16'h0000;
      remain   <= 8'h00;
      byte_cnt <= 8'h00;
      head     <= 2'h0;
      hi_half  <= 1'b1;
      f_data   <= 8'h00;
      f_valid  <= 1'b0;
      f_last   <= 1'b0;
      echo_i   <= 3'h0;
      coil_wr  <= 1'b0;
      coil_addr <= {CAW{1'b0}};
      coil_val <= 1'b0;
      busy     <= 1'b0;
      q[0]     <= 8'h00;
      q[1]     <= 8'h00;
      q[2]     <= 8'h00;
      q[3]     <= 8'h00;
      q[4]     <= 8'h00;
      q[5]     <= 8'h00;
    end else begin
      coil_wr <= 1'b0;
      if (f_valid && f_ready) begin
        f_valid <= 1'b0;
        f_last  <= 1'b0;
      end
      case (state)
        S_RX: begin
          busy <= 1'b0;
          if (rx_valid && rx_cnt < `MBS_QUERY_LEN) begin
            q[rx_cnt] <= rx_data;
            rx_cnt    <= rx_cnt + 3'h1;
          end
          if (rx_end) begin
            rx_cnt <= 3'h0;
            if (rx_check_ok && rx_cnt == `MBS_QUERY_LEN) begin
              state <= S_EXEC;
              busy  <= 1'b1;
            end
          end
        end
        S_EXEC: begin
          state <= S_RX;
          if (mine && is_bits && bits_ok) begin
            byte_cnt <= q_qty[10:3] + {7'h00, q_qty[2:0] != 3'h0};
            remain   <= q_qty[10:3] + {7'h00, q_qty[2:0] != 3'h0};
            idx      <= q_start;
            head     <= 2'h0;
            state    <= S_HEAD;
          end else if (mine && is_regs && regs_ok) begin
            byte_cnt <= {q_qty[6:0], 1'b0};
            remain   <= {q_qty[6:0], 1'b0};
            idx      <= q_start;
            hi_half  <= 1'b1;
            head     <= 2'h0;
            state    <= S_HEAD;
          end else if ((mine || (bcast && ok_on_bcast(q[1]))) &&
                       q[1] == `MBS_FN_FORCE_COIL && coil_ok) begin
            coil_addr <= q_start[CAW-1:0];
            coil_val  <= (q_qty == `MBS_COIL_ON);
            coil_wr   <= (q_qty == `MBS_COIL_ON) || (q_qty == `MBS_COIL_OFF);
            echo_i    <= 3'h0;
            state     <= mine ? S_ECHO : S_RX;
          end
        end
        S_HEAD: if (!f_valid || f_ready) begin
          f_valid <= 1'b1;
          f_data  <= (head == 2'h0) ? q[0] : (head == 2'h1) ? q[1] : byte_cnt;
          head    <= head + 2'h1;
          if (head == 2'h2)
            state <= S_DATA;
        end
        S_DATA: if (!f_valid || f_ready) begin
          f_valid <= 1'b1;
          f_last  <= (remain == 8'h01);
          remain  <= remain - 8'h01;
          if (is_bits) begin
            f_data <= bit_byte(snap_bits, idx, (remain == 8'h01 && q_qty[2:0] != 3'h0) ?
                               {5'h00, q_qty[2:0]} : 8'h08);
            idx    <= idx + 16'h0008;
          end else begin
            f_data  <= reg_byte((q[1] == `MBS_FN_RD_HOLD) ? snap_hold : snap_inreg,
                                idx, hi_half);
            hi_half <= !hi_half;
            if (!hi_half)
              idx <= idx + 16'h0001;
          end
          if (remain == 8'h01)
            state <= S_RX;
        end
        S_ECHO: if (!f_valid || f_ready) begin
          f_valid <= 1'b1;
          f_data  <= q[echo_i];
          f_last  <= (echo_i == 3'h5);
          echo_i  <= echo_i + 3'h1;
          if (echo_i == 3'h5)
            state <= S_RX;
        end
        default: state <= S_RX;
      endcase
    end
  end
endmodule

/* File: verilog/mbs_regs.vh */
/*
  constants for the query handler: function codes, limits, frame layout.
  assumes: included by mbs_handler.v by bare name; mbs_fifo.v does not include it.
*/
`ifndef MBS_REGS_VH
`define MBS_REGS_VH
`define MBS_FN_RD_INPUTS  8'h02
`define MBS_FN_RD_HOLD    8'h03
`define MBS_FN_RD_INREG   8'h04
`define MBS_FN_FORCE_COIL 8'h05
`define MBS_FN_PRESET_REG 8'h06
`define MBS_FN_FORCE_MULT 8'h0F
`define MBS_FN_PRESET_MUL 8'h10
`define MBS_BCAST_ADDR    8'h00
`define MBS_MAX_BITS      16'h07D0
`define MBS_MAX_REGS      16'h007D
`define MBS_COIL_ON       16'hFF00
`define MBS_COIL_OFF      16'h0000
`define MBS_QUERY_LEN     4'h6
`endif

/* File: verilog/mbs_fifo.v */
/*
  byte fifo on the answer path, flip-flop storage indexed by pointer.
  assumes: one clock, reader may stall to apply back-pressure.
*/
module mbs_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             mclk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output reg  [WIDTH-1:0] out_data,
  output reg              out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr;
  reg [AW:0]      rd_ptr;
  wire [AW:0]     level = wr_ptr - rd_ptr;
  wire            empty = (level == {(AW+1){1'b0}});
  wire            pop   = (!out_valid || out_ready) && !empty;
  wire            push  = in_valid && in_ready;
  assign in_ready = (level != DEPTH[AW:0]) || (DEPTH == (1 << AW) && level[AW] == 1'b0);

  always @(posedge mclk) begin
    if (push)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr    <= {(AW+1){1'b0}};
      rd_ptr    <= {(AW+1){1'b0}};
      out_data  <= {WIDTH{1'b0}};
      out_valid <= 1'b0;
    end else begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop) begin
        out_data  <= mem[rd_ptr[AW-1:0]];
        out_valid <= 1'b1;
        rd_ptr    <= rd_ptr + 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end
endmodule

/* File: sim/mbs_handler_properties.sv */
/* port assertions for the query handler.
   assumes: bound into every mbs_handler, one clock domain. */
module mbs_handler_properties #(
  parameter COILS = 256,
  parameter CAW   = 8
) (
  input wire logic             mclk,
  input wire logic             rst_n,
  input wire logic [7:0]       slave_id,
  input wire logic             rx_end,
  input wire logic             rx_check_ok,
  input wire logic [COILS-1:0] coil_state,
  input wire logic             coil_wr,
  input wire logic [CAW-1:0]   coil_addr,
  input wire logic             coil_val,
  input wire logic [7:0]       tx_data,
  input wire logic             tx_valid,
  input wire logic             tx_last,
  input wire logic             tx_ready,
  input wire logic             busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt;
  // index of the answer byte, saturating
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      cnt <= 2'h0;
    else if (tx_valid && tx_ready)
      cnt <= tx_last ? 2'h0 : cnt + {1'b0, cnt != 2'h3};
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_coil_src; coil_wr |-> $past(rx_end, 2); endproperty
  a_coil_src: assert property (p_coil_src) else $error("coil write without frame");
  property p_coil_set; coil_wr |-> ##[0:1] (coil_state[coil_addr] == coil_val); endproperty
  a_coil_set: assert property (p_coil_set) else $error("coil not updated");
  property p_persist; !coil_wr && !$past(coil_wr) |-> $stable(coil_state); endproperty
  a_persist: assert property (p_persist) else $error("coil changed unasked");
  property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last);
  endproperty
  a_hold: assert property (p_hold) else $error("answer byte dropped while stalled");
  property p_last; tx_last |-> tx_valid; endproperty
  a_last: assert property (p_last) else $error("last flag without byte");
  property p_first; tx_valid && cnt == 2'h0 |-> tx_data == slave_id; endproperty
  a_first: assert property (p_first) else $error("answer not led by own address");
  property p_func; tx_valid && cnt == 2'h1 |-> tx_data inside {8'h02, 8'h03, 8'h04, 8'h05};
  endproperty
  a_func: assert property (p_func) else $error("bad function in answer");
  property p_bad_check; rx_end && !rx_check_ok && !busy |=> (!tx_valid && !coil_wr) [*8];
  endproperty
  a_bad_check: assert property (p_bad_check) else $error("bad frame acted on");
  property p_delay; rx_end && !busy |=> !tx_valid [*3]; endproperty
  a_delay: assert property (p_delay) else $error("answer too early");
  c_force: cover property (coil_wr && coil_val);
  c_done: cover property (tx_valid && tx_ready && tx_last);
  c_bad: cover property (rx_end && !rx_check_ok);
endmodule

bind mbs_handler mbs_handler_properties #(.COILS(COILS), .CAW(CAW)) chk (
  .mclk(mclk), .rst_n(rst_n), .slave_id(slave_id), .rx_end(rx_end),
  .rx_check_ok(rx_check_ok), .coil_state(coil_state), .coil_wr(coil_wr),
  .coil_addr(coil_addr), .coil_val(coil_val), .tx_data(tx_data), .tx_valid(tx_valid),
  .tx_last(tx_last), .tx_ready(tx_ready), .busy(busy)
);

/* File: sim/mbs_master.sv */
/* master model: sends framed queries, drains answers with optional stalls.
   assumes: driven at falling edges, bench sets slow for back-pressure. */
module mbs_master (
  input  wire logic mclk,
  input  wire logic tx_valid,
  input  wire logic tx_last,
  output logic [7:0] rx_data,
  output logic       rx_valid,
  output logic       rx_end,
  output logic       rx_check_ok,
  output logic       tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic slow = 1'b0;
  integer lost = 0;
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    rx_end = 1'b0;
    rx_check_ok = 1'b0;
  end
  always @(negedge mclk)
    tx_ready <= slow ? 1'($urandom_range(1)) : 1'b1;
  // quantities kept within limits unless refusal is intended
  task xfer(input logic [47:0] q, input logic ok, input logic ans);
    integer i;
    for (i = 0; i < 6; i++) begin
      @(negedge mclk);
      rx_data = q[47-8*i -: 8];
      rx_valid = 1'b1;
    end
    @(negedge mclk);
    rx_valid = 1'b0;
    rx_data = ~rx_data;
    rx_end = 1'b1;
    rx_check_ok = ok;
    @(negedge mclk);
    rx_end = 1'b0;
    rx_check_ok = 1'b0;
    i = 0;
    // next query only after the answer's last byte is taken or 300 cycles pass
    while (ans && i < 300) begin
      @(posedge mclk);
      i = (tx_valid && tx_ready && tx_last) ? 400 : i + 1;
    end
    // an answer that never closes is counted for the bench
    if (ans && i == 300)
      lost++;
    repeat (20) @(negedge mclk);
  endtask
endmodule

/* File: sim/test_mbs_handler.sv */
/* bench for the query handler: queued expectations, byte monitor.
   assumes: small tables, master model on the query and answer side. */
module test_mbs_handler;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ID = 8'h2B;
  logic [7:0] sid = ID;
  logic mclk = 1'b0, rst_n = 1'b0, scan_end = 1'b0;
  logic [15:0] in_bits = 16'h0000, sb;
  logic [63:0] hold_regs = 64'h0, in_regs = 64'h0, sh, si;
  logic [15:0] coil_state;
  logic [3:0]  coil_addr;
  logic [7:0]  rx_data, tx_data, e;
  logic rx_valid, rx_end, rx_check_ok, tx_ready, tx_valid, tx_last, coil_wr, coil_val, busy;
  logic [7:0] exp_q[$];
  integer fails = 0, num_checks = 0, cyc = 0;
  mbs_handler #(.INPUTS(16), .REGS(4), .COILS(16), .IAW(4), .RAW(2), .CAW(4)) dut (
    .mclk(mclk), .rst_n(rst_n), .slave_id(sid), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_end(rx_end), .rx_check_ok(rx_check_ok), .scan_end(scan_end), .in_bits(in_bits),
    .hold_regs(hold_regs), .in_regs(in_regs), .coil_state(coil_state), .coil_wr(coil_wr),
    .coil_addr(coil_addr), .coil_val(coil_val), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_last(tx_last), .tx_ready(tx_ready), .busy(busy));
  mbs_master m (.mclk(mclk), .tx_valid(tx_valid), .tx_last(tx_last), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_end(rx_end), .rx_check_ok(rx_check_ok), .tx_ready(tx_ready));
  initial begin
    forever #5 mclk = ~mclk;
  end
  task check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      summarize;
    end
  end
  always @(posedge mclk)
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q[0] : ~tx_data;
      check({7'h0, tx_last, tx_data}, {7'h0, exp_q.size() == 1, e}, "tx");
      if (exp_q.size() > 0)
        void'(exp_q.pop_front());
    end
  // later table changes must not reach answers before the next scan end
  task scan;
    @(negedge mclk);
    in_bits = 16'($urandom);
    hold_regs = {$urandom, $urandom};
    in_regs = {$urandom, $urandom};
    {sb, sh, si} = {in_bits, hold_regs, in_regs};
    scan_end = 1'b1;
    @(negedge mclk);
    scan_end = 1'b0;
    {in_bits, hold_regs, in_regs} = ~{sb, sh, si};
  endtask
  task qry(input logic [7:0] ad, fn, input logic [15:0] st, qt, input logic ok, ans);
    integer i, k, n;
    logic [7:0] b;
    logic [63:0] t;
    t = (fn == 8'h03) ? sh : si;
    if (ans) begin
      exp_q.push_back(ad);
      exp_q.push_back(fn);
      if (fn == 8'h05) begin
        {b, e} = st;
        exp_q.push_back(b);
        exp_q.push_back(e);
        {b, e} = qt;
        exp_q.push_back(b);
        exp_q.push_back(e);
      end else if (fn == 8'h02) begin
        n = (qt + 7) / 8;
        exp_q.push_back(8'(n));
        for (i = 0; i < n; i++) begin
          b = 8'h00;
          for (k = 0; k < 8; k++)
            if (8 * i + k < qt)
              b[k] = sb[st+8*i+k];
          exp_q.push_back(b);
        end
      end else begin
        exp_q.push_back(8'(2 * qt));
        for (i = 0; i < qt; i++) begin
          exp_q.push_back(t[16*(st+i)+8 +: 8]);
          exp_q.push_back(t[16*(st+i) +: 8]);
        end
      end
    end
    m.xfer({ad, fn, st, qt}, ok, ans);
  endtask
  initial begin
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    void'($urandom(32'hA9F408D8));
    scan();
    qry(ID, 8'h02, 16'h0003, 16'h000A, 1'b1, 1'b1);
    qry(ID, 8'h02, 16'h0000, 16'h0010, 1'b1, 1'b1);
    m.slow = 1'b1;
    qry(ID, 8'h03, 16'h0001, 16'h0003, 1'b1, 1'b1);
    qry(ID, 8'h04, 16'h0000, 16'h0004, 1'b1, 1'b1);
    m.slow = 1'b0;
    qry(ID, 8'h05, 16'h0005, 16'hFF00, 1'b1, 1'b1);
    check(coil_state[5], 1'b1, "coil 5 on");
    qry(ID, 8'h05, 16'h0005, 16'h1234, 1'b1, 1'b1);
    check(coil_state[5], 1'b1, "coil 5 kept");
    qry(ID, 8'h05, 16'h0005, 16'h0000, 1'b1, 1'b1);
    check(coil_state[5], 1'b0, "coil 5 off");
    qry(8'h00, 8'h05, 16'h0009, 16'hFF00, 1'b1, 1'b0);
    check(coil_state[9], 1'b1, "coil 9 broadcast");
    for (int f = 2; f < 5; f++)
      qry(8'h00, 8'(f), 16'h0000, 16'h0001, 1'b1, 1'b0);
    qry(ID, 8'h03, 16'h0000, 16'h0001, 1'b0, 1'b0);
    qry(ID, 8'h02, 16'h0000, 16'h0000, 1'b1, 1'b0);
    qry(ID, 8'h03, 16'h0000, 16'h0005, 1'b1, 1'b0);
    qry(ID + 8'h01, 8'h03, 16'h0000, 16'h0001, 1'b1, 1'b0);
    qry(ID, 8'h05, 16'h0005, 16'hFF00, 1'b0, 1'b0);
    check(coil_state[5], 1'b0, "coil 5 after bad check");
    // mid-run reset: forced coils must survive it
    @(negedge mclk);
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    check(coil_state[9], 1'b1, "coil 9 persists");
    sid = 8'($urandom_range(255, 1));
    scan();
    qry(sid, 8'h04, 16'h0002, 16'h0002, 1'b1, 1'b1);
    qry(sid ^ 8'h80, 8'h03, 16'h0000, 16'h0001, 1'b1, 1'b0);
    check(m.lost, 16'h0000, "answer timeouts");
    check(exp_q.size(), 16'h0000, "answers left");
    summarize;
  end
endmodule
